//--- rtl/oifc_pkg.sv
// oifc_pkg: constants, register map and types of the output inhibit and
// fault control block.
// assumes one 25 MHz clock and a 32-bit AHB-Lite register bus.
package oifc_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  // voltage ramp-down time before the relay opens on a normal disable
  localparam int RAMP_DOWN_US = 100;
  localparam int RAMP_DOWN_CYC = RAMP_DOWN_US * CLK_MHZ;
  localparam int RAMP_W = 16;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT = 8'h00;
  localparam logic [7:0] ADDR_CLR = 8'h04;
  localparam logic [7:0] ADDR_INH = 8'h08;
  localparam logic [7:0] ADDR_DFI = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // fields
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_IMM_BIT = 1;
  localparam int CLR_BIT = 0;
  localparam int INH_POL_BIT = 0;
  localparam int INH_MODE_LSB = 1;
  localparam int DFI_EN_BIT = 0;
  localparam int DFI_SRC_LSB = 1;
  localparam int ST_OUT_BIT = 0;
  localparam int ST_RELAY_BIT = 1;
  localparam int ST_AMP_BIT = 2;
  localparam int ST_LATCH_BIT = 3;
  localparam int ST_SAVED_BIT = 4;
  localparam int ST_INH_BIT = 5;
  localparam int ST_WAIT_BIT = 6;
  localparam int ST_DFI_BIT = 7;
  localparam int ST_FAULT_LSB = 8;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FOLLOW_INHIBIT_MODE = 2'h0,
    LATCHED_INHIBIT_MODE = 2'h1,
    IGNORE_INHIBIT_MODE = 2'h2
  } oifc_inh_mode_e;

  typedef enum logic [2:0] {
    SRC_NEVER = 3'h0,
    QUESTIONABLE_SUMMARY_SRC = 3'h1,
    OPERATION_SUMMARY_SRC = 3'h2,
    STD_EVENT_SUMMARY_SRC = 3'h3,
    SERVICE_REQUEST_SUMMARY_SRC = 3'h4
  } oifc_dfi_src_e;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_WAIT_AUX = 3'b010,
    ST_RUN = 3'b100
  } oifc_state_e;

  typedef struct packed {
    logic over_temperature_fault;
    logic over_current_fault;
    logic over_voltage_fault;
  } oifc_fault_s;

  typedef struct packed {
    logic service_request;
    logic std_event;
    logic operation;
    logic questionable;
  } oifc_sum_s;

  // reset values
  localparam logic RST_INH_POL = 1'b0;
  localparam oifc_inh_mode_e RST_INH_MODE = FOLLOW_INHIBIT_MODE;
  localparam oifc_dfi_src_e RST_DFI_SRC = SRC_NEVER;

endpackage : oifc_pkg

//--- rtl/oifc_pin_sync.sv
// oifc_pin_sync: two-flop synchronisers for the inhibit and fault pins,
// plus inhibit polarity decode.
// assumes all pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module oifc_pin_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic remote_inhibit_input,
  input wire oifc_pkg::oifc_fault_s fault_pin,
  input wire logic inh_pol,
  output logic inh_pin_s,
  output logic inh_act,
  output oifc_pkg::oifc_fault_s fault_s
);
  import oifc_pkg::*;

  localparam int N = 4;
  // inhibit idles high (open contact, pulled up), faults idle low
  localparam logic [N-1:0] SYNC_RST = 4'h8;

  logic [N-1:0] raw;
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;

  assign raw = {remote_inhibit_input, fault_pin};

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_r[i] <= SYNC_RST[i];
          sync_r[i] <= SYNC_RST[i];
        end else begin
          meta_r[i] <= raw[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign fault_s = sync_r[2:0];
  assign inh_pin_s = sync_r[3];
  // low polarity: a closed contact (low) inhibits; high inverts it
  assign inh_act = inh_pol ? sync_r[3] : ~sync_r[3];

endmodule : oifc_pin_sync
`default_nettype wire

//--- rtl/oifc_top.sv
// oifc_top: output enable, relay sequencing, protection latch, remote
// inhibit handling and discrete fault indicator, with an AHB-Lite slave.
// assumes a single-master AHB-Lite bus, word transfers, one clock, and a
// non-volatile store that presents the saved inhibit settings at reset.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - disabled output means zero amplitude, relays open; reset disabled; reads 0/1.
// - with sink and regen, immediate-off opens relay unramped; else normal disable.
// - over-voltage, current, temperature or inhibit faults set a disabling latch.
// - latch clear succeeds only once every causing condition has gone.
// - clearing the latch restores the enable state held before the fault.
// - inhibit polarity defaults low (closed contact inhibits); high inverts it.
// - inhibit polarity is kept in non-volatile storage, restored at power-up.
// - inhibit must be open during init; closed halts init, flags waiting.
// - latched_inhibit_mode mode: inhibit sets the latch, only the clear command releases it.
// - follow mode: output follows inhibit continuously, off then back on.
// - ignore mode: inhibit input disregarded except by the init check.
// - inhibit mode saved and restored; default and reset value is follow.
// - fault indicator active high with own enable, reset disabled.
// - indicator source picks one of four summaries or never-true; reset never.
module oifc_top #(
  parameter int RAMP_CYC = oifc_pkg::RAMP_DOWN_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic remote_inhibit_input,
  input wire oifc_pkg::oifc_fault_s fault_pin,
  input wire logic sink_option,
  input wire logic regen_mode,
  input wire oifc_pkg::oifc_sum_s summary,
  input wire logic nv_inh_pol,
  input wire logic [1:0] nv_inh_mode,
  output logic amp_on,
  output logic relay_close,
  output logic prot_latched,
  output logic init_wait_aux,
  output logic discrete_fault_indicator,
  output logic inh_pol_store,
  output logic [1:0] inh_mode_store
);
  import oifc_pkg::*;

  if (RAMP_CYC < 1 || RAMP_CYC >= (1 << RAMP_W)) begin : g_bad_ramp
    $error("oifc_top: RAMP_CYC out of range");
  end

  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(RAMP_CYC - 1);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  oifc_state_e state_r;
  oifc_inh_mode_e inh_mode_r;
  oifc_dfi_src_e dfi_src_r;
  logic inh_pol_r;
  logic enable_r;
  logic saved_en_r;
  logic latch_r;
  logic imm_r;
  logic dfi_en_r;
  logic [RAMP_W-1:0] ramp_cnt_r;
  logic ramping_r;
  logic nv_load_r;

  // bus data-phase capture
  logic dp_wr_r;
  logic [7:0] dp_addr_r;

  // synchronised pins
  logic inh_pin_s;
  logic inh_act;
  oifc_fault_s fault_s;

  oifc_pin_sync u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .remote_inhibit_input(remote_inhibit_input),
    .fault_pin(fault_pin),
    .inh_pol(inh_pol_r),
    .inh_pin_s(inh_pin_s),
    .inh_act(inh_act),
    .fault_s(fault_s)
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic addr_take;
  logic wr_out;
  logic wr_clr;
  logic wr_inh;
  logic wr_dfi;
  logic [1:0] wmode;
  logic [2:0] wsrc;

  assign addr_take = hsel && htrans[1] && hready;
  assign wr_out = dp_wr_r && (dp_addr_r == ADDR_OUT);
  assign wr_clr = dp_wr_r && (dp_addr_r == ADDR_CLR) && hwdata[CLR_BIT];
  assign wr_inh = dp_wr_r && (dp_addr_r == ADDR_INH);
  assign wr_dfi = dp_wr_r && (dp_addr_r == ADDR_DFI);
  assign wmode = hwdata[INH_MODE_LSB +: 2];
  assign wsrc = hwdata[DFI_SRC_LSB +: 3];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= addr_take && hwrite;
      dp_addr_r <= {haddr[7:2], 2'b00};
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // initialisation sequence
  // ----------------------------------------------------------------------
  // the pin synchroniser shows its open reset level for two edges after
  // release; judging the contact earlier would miss a closed one
  logic [1:0] settle_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle_r <= 2'h0;
    end else if (settle_r != 2'h2) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // a closed inhibit contact reads low on the pin, whatever the polarity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_INIT;
    end else begin
      case (state_r)
        ST_INIT: begin
          if (settle_r != 2'h2) begin
            state_r <= ST_INIT;
          end else if (!inh_pin_s) begin
            state_r <= ST_WAIT_AUX;
          end else begin
            state_r <= ST_RUN;
          end
        end
        ST_WAIT_AUX: begin
          if (inh_pin_s) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_wait_aux <= 1'b0;
    end else begin
      init_wait_aux <= (state_r == ST_WAIT_AUX) ||
                       (state_r == ST_INIT && !inh_pin_s);
    end
  end

  // ----------------------------------------------------------------------
  // inhibit configuration, restored from non-volatile store
  // ----------------------------------------------------------------------
  // the stored values are caught one edge after reset release, never under
  // reset itself; until then the defaults stand
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nv_load_r <= 1'b1;
    end else begin
      nv_load_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inh_pol_r <= RST_INH_POL;
      inh_mode_r <= RST_INH_MODE;
    end else if (nv_load_r) begin
      inh_pol_r <= nv_inh_pol;
      if (nv_inh_mode <= 2'h2) begin
        inh_mode_r <= oifc_inh_mode_e'(nv_inh_mode);
      end
    end else if (wr_inh) begin
      inh_pol_r <= hwdata[INH_POL_BIT];
      if (wmode <= 2'h2) begin
        inh_mode_r <= oifc_inh_mode_e'(wmode);
      end
    end
  end

  // current settings go out to the store so they survive power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inh_pol_store <= RST_INH_POL;
      inh_mode_store <= RST_INH_MODE;
    end else begin
      inh_pol_store <= inh_pol_r;
      inh_mode_store <= inh_mode_r;
    end
  end

  // ----------------------------------------------------------------------
  // protection latch
  // ----------------------------------------------------------------------
  logic running;
  logic fault_any;
  logic latch_set;
  logic latch_clr;
  logic follow_inhibit_mode_off;

  assign running = (state_r == ST_RUN);
  assign fault_any = |fault_s;
  // ignore mode leaves the inhibit out of every term below
  assign latch_set = running && (fault_any ||
    (inh_mode_r == LATCHED_INHIBIT_MODE && inh_act));
  // clear refused while any cause remains; set wins over clear
  assign latch_clr = wr_clr && !latch_set;
  assign follow_inhibit_mode_off = (inh_mode_r == FOLLOW_INHIBIT_MODE) && inh_act;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_r <= 1'b0;
    end else if (latch_set) begin
      latch_r <= 1'b1;
    end else if (latch_clr) begin
      latch_r <= 1'b0;
    end
  end

  // enable state at the moment of the fault
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      saved_en_r <= 1'b0;
    end else if (latch_set && !latch_r) begin
      saved_en_r <= enable_r;
    end else if (latch_r && wr_out) begin
      saved_en_r <= saved_en_r;
    end
  end

  // ----------------------------------------------------------------------
  // output enable
  // ----------------------------------------------------------------------
  logic imm_req;

  // the immediate variant only skips the ramp with sink fitted and regen on
  assign imm_req = hwdata[OUT_IMM_BIT] && sink_option && regen_mode;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_r <= 1'b0;
    end else if (latch_r && latch_clr) begin
      enable_r <= saved_en_r;
    end else if (wr_out) begin
      enable_r <= hwdata[OUT_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      imm_r <= 1'b0;
    end else if (wr_out) begin
      imm_r <= imm_req && !hwdata[OUT_EN_BIT];
    end else if (!relay_close) begin
      imm_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // amplitude and relay sequencing
  // ----------------------------------------------------------------------
  logic drive;
  logic fast_open;

  assign drive = running && enable_r && !latch_r && !follow_inhibit_mode_off;
  // protection and inhibit trips open at once rather than ramping
  assign fast_open = imm_r || latch_r || follow_inhibit_mode_off;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      amp_on <= 1'b0;
    end else begin
      amp_on <= drive;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramping_r <= 1'b0;
      ramp_cnt_r <= '0;
    end else if (drive || !relay_close || fast_open) begin
      ramping_r <= 1'b0;
      ramp_cnt_r <= '0;
    end else if (!ramping_r) begin
      ramping_r <= 1'b1;
      ramp_cnt_r <= '0;
    end else if (ramp_cnt_r != RAMP_LAST) begin
      ramp_cnt_r <= ramp_cnt_r + RAMP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      relay_close <= 1'b0;
    end else if (drive) begin
      relay_close <= 1'b1;
    end else if (fast_open) begin
      relay_close <= 1'b0;
    end else if (ramping_r && ramp_cnt_r == RAMP_LAST) begin
      relay_close <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_latched <= 1'b0;
    end else begin
      prot_latched <= latch_r;
    end
  end

  // ----------------------------------------------------------------------
  // discrete fault indicator
  // ----------------------------------------------------------------------
  logic dfi_sel;

  always_comb begin
    case (dfi_src_r)
      QUESTIONABLE_SUMMARY_SRC: dfi_sel = summary.questionable;
      OPERATION_SUMMARY_SRC: dfi_sel = summary.operation;
      STD_EVENT_SUMMARY_SRC: dfi_sel = summary.std_event;
      SERVICE_REQUEST_SUMMARY_SRC: dfi_sel = summary.service_request;
      default: dfi_sel = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dfi_en_r <= 1'b0;
      dfi_src_r <= RST_DFI_SRC;
    end else if (wr_dfi) begin
      dfi_en_r <= hwdata[DFI_EN_BIT];
      if (wsrc <= 3'h4) begin
        dfi_src_r <= oifc_dfi_src_e'(wsrc);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      discrete_fault_indicator <= 1'b0;
    end else begin
      discrete_fault_indicator <= dfi_en_r && dfi_sel;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      ADDR_OUT: rd_val[OUT_EN_BIT] = enable_r;
      ADDR_INH: begin
        rd_val[INH_POL_BIT] = inh_pol_r;
        rd_val[INH_MODE_LSB +: 2] = inh_mode_r;
      end
      ADDR_DFI: begin
        rd_val[DFI_EN_BIT] = dfi_en_r;
        rd_val[DFI_SRC_LSB +: 3] = dfi_src_r;
      end
      ADDR_STAT: begin
        rd_val[ST_OUT_BIT] = enable_r;
        rd_val[ST_RELAY_BIT] = relay_close;
        rd_val[ST_AMP_BIT] = amp_on;
        rd_val[ST_LATCH_BIT] = latch_r;
        rd_val[ST_SAVED_BIT] = saved_en_r;
        rd_val[ST_INH_BIT] = inh_act;
        rd_val[ST_WAIT_BIT] = init_wait_aux;
        rd_val[ST_DFI_BIT] = discrete_fault_indicator;
        rd_val[ST_FAULT_LSB +: 3] = fault_s;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // captured in the address phase, so it stands through the data phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rd_val;
    end
  end

endmodule : oifc_top
`default_nettype wire

//--- tb/oifc_monitor.sv
// oifc_monitor: concurrent checks on the ports of oifc_top.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module oifc_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire oifc_pkg::oifc_fault_s fault_pin,
  input wire oifc_pkg::oifc_sum_s summary,
  input wire logic amp_on,
  input wire logic relay_close,
  input wire logic prot_latched,
  input wire logic init_wait_aux,
  input wire logic discrete_fault_indicator,
  input wire logic [1:0] inh_mode_store
);
  import oifc_pkg::*;
  logic any_sum;
  assign any_sum = |summary;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------------------------------------------
  // protection latch
  // --------------------------------------------------------------------
  // five cycles covers the two-flop pin synchroniser plus the latch flop
  sequence s_fault_held;
    (|fault_pin)[*5];
  endsequence
  sequence s_tripped;
    ##[0:2] (prot_latched && !amp_on && !relay_close);
  endsequence
  a_fault_trips: assert property (s_fault_held |-> s_tripped)
    else $error("fault on pin did not trip the latch");
  a_clear_blocked: assert property ((prot_latched && |fault_pin)[*6] |=> prot_latched)
    else $error("latch released while a fault stood");
  a_latch_off: assert property (prot_latched |-> !amp_on && !relay_close)
    else $error("output follow_inhibit_mode while latched");
  a_amp_relay: assert property (amp_on |-> relay_close)
    else $error("amplitude on with relay open");
  a_init_quiet: assert property (init_wait_aux |-> !relay_close && !amp_on)
    else $error("output follow_inhibit_mode while waiting for inhibit");
  // --------------------------------------------------------------------
  // reset, bus and indicator
  // --------------------------------------------------------------------
  a_reset_quiet: assert property ($fell(sys_rst) |-> !amp_on && !relay_close
      && !prot_latched && !discrete_fault_indicator)
    else $error("outputs not idle after reset");
  a_ready_rst: assert property ($fell(sys_rst) |-> !hreadyout ##1 hreadyout)
    else $error("bus ready timing after reset");
  a_bus_okay: assert property (!sys_rst |=> hreadyout && !hresp)
    else $error("bus not ready or error response");
  a_dfi_cause: assert property ($rose(discrete_fault_indicator) |-> $past(any_sum))
    else $error("indicator rose with no summary true");
  a_dfi_quiet: assert property ((!any_sum)[*2] |-> !discrete_fault_indicator)
    else $error("indicator high with no summary true");
  a_mode_legal: assert property (inh_mode_store != 2'h3)
    else $error("stored inhibit mode illegal");
endmodule : oifc_monitor
bind oifc_top oifc_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .hresp(hresp), .fault_pin(fault_pin),
  .summary(summary), .amp_on(amp_on), .relay_close(relay_close),
  .prot_latched(prot_latched), .init_wait_aux(init_wait_aux),
  .discrete_fault_indicator(discrete_fault_indicator),
  .inh_mode_store(inh_mode_store));
`default_nettype wire

//--- tb/oifc_pin_model.sv
// oifc_pin_model: external inhibit contact and fault sources.
// assumes the inhibit line has a pull-up, so an open contact reads high.
`timescale 1ns/1ps
`default_nettype none
module oifc_pin_model (
  input wire logic contact_closed,
  input wire oifc_pkg::oifc_fault_s fault_req,
  output logic remote_inhibit_input,
  output oifc_pkg::oifc_fault_s fault_pin
);
  // a closed contact pulls the line low, the pull-up wins otherwise
  assign remote_inhibit_input = contact_closed ? 1'b0 : 1'b1;
  assign fault_pin = fault_req;
endmodule : oifc_pin_model
`default_nettype wire

//--- tb/oifc_tb_top.sv
// oifc_tb_top: self-checking bench for oifc_top over AHB-Lite.
// assumes the pin model on the inhibit and fault pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  errors++; $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module oifc_tb_top;
  import oifc_pkg::*;
  localparam int RAMP = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic sys_rst, hsel, hwrite, hreadyout, hresp, sink_option, regen_mode;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, nv_inh_mode, inh_mode_store;
  logic [2:0] hsize;
  logic remote_inhibit_input, nv_inh_pol, amp_on, relay_close, prot_latched;
  logic init_wait_aux, discrete_fault_indicator, inh_pol_store, contact;
  oifc_fault_s fault_pin, fault_req;
  oifc_sum_s summary;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  oifc_top #(.RAMP_CYC(RAMP)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .remote_inhibit_input(remote_inhibit_input), .fault_pin(fault_pin),
    .sink_option(sink_option), .regen_mode(regen_mode), .summary(summary),
    .nv_inh_pol(nv_inh_pol), .nv_inh_mode(nv_inh_mode), .amp_on(amp_on),
    .relay_close(relay_close), .prot_latched(prot_latched),
    .init_wait_aux(init_wait_aux),
    .discrete_fault_indicator(discrete_fault_indicator),
    .inh_pol_store(inh_pol_store), .inh_mode_store(inh_mode_store));
  oifc_pin_model u_pins (.contact_closed(contact), .fault_req(fault_req),
    .remote_inhibit_input(remote_inhibit_input), .fault_pin(fault_pin));
  // --------------------------------------------------------------------
  // bus and helpers
  // --------------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      conclude();
    end
  end
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    ahb(0, ADDR_OUT, 0);
    `CHK("out_reg", 32'h0, d);
    ahb(0, ADDR_INH, 0);
    `CHK("inh_reg", 32'h0, d);
    ahb(0, ADDR_DFI, 0);
    `CHK("dfi_reg", 32'h0, d);
    ahb(1, 8'h20, 32'hffff_ffff);
    ahb(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, d);
    ahb(1, ADDR_OUT, 32'h1);
    ahb(0, ADDR_OUT, 0);
    `CHK("out_query", 32'h1, d);
  endtask : t_reset
  // single-phase model: no phase coupling step before the relay closes
  task automatic t_enable();
    wt(2);
    `CHK("amp_on", 1'b1, amp_on);
    `CHK("relay", 1'b1, relay_close);
    ahb(1, ADDR_OUT, 32'h0);
    wt(2);
    `CHK("amp_off", 1'b0, amp_on);
    `CHK("relay_ramp", 1'b1, relay_close);
    wt(RAMP + 4);
    `CHK("relay_open", 1'b0, relay_close);
  endtask : t_enable
  task automatic t_immediate();
    for (int i = 0; i < 4; i++) begin
      sink_option <= i[0];
      regen_mode <= i[1];
      ahb(1, ADDR_OUT, 32'h1);
      wt(2);
      ahb(1, ADDR_OUT, 32'h2);
      wt(3);
      `CHK("imm_amp", 1'b0, amp_on);
      `CHK("imm_relay", logic'(i != 3), relay_close);
      wt(RAMP + 4);
      `CHK("imm_done", 1'b0, relay_close);
    end
  endtask : t_immediate
  task automatic t_fault();
    logic en;
    for (int i = 0; i < 3; i++) begin
      en = (i != 1);
      ahb(1, ADDR_OUT, {31'h0, en});
      fault_req <= oifc_fault_s'(3'h1 << i);
      wt(6);
      `CHK("latched", 1'b1, prot_latched);
      `CHK("trip_amp", 1'b0, amp_on);
      `CHK("trip_relay", 1'b0, relay_close);
      ahb(0, ADDR_STAT, 0);
      `CHK("stat_latch", 1'b1, d[ST_LATCH_BIT]);
      ahb(1, ADDR_CLR, 32'h1);
      wt(3);
      `CHK("clr_refused", 1'b1, prot_latched);
      fault_req <= '0;
      wt(5);
      ahb(1, ADDR_CLR, 32'h1);
      wt(3);
      `CHK("clr_taken", 1'b0, prot_latched);
      `CHK("restored_amp", en, amp_on);
      `CHK("restored_relay", en, relay_close);
      ahb(1, ADDR_OUT, 32'h0);
      wt(RAMP + 4);
    end
  endtask : t_fault
  task automatic t_inhibit();
    logic pol_t [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    oifc_inh_mode_e mode_t [4] = '{FOLLOW_INHIBIT_MODE, FOLLOW_INHIBIT_MODE,
      IGNORE_INHIBIT_MODE, LATCHED_INHIBIT_MODE};
    ahb(1, ADDR_OUT, 32'h1);
    for (int r = 0; r < 4; r++) begin
      // idle contact level flips with polarity: closed is idle when high
      contact <= pol_t[r];
      wt(4);
      ahb(1, ADDR_INH, {29'h0, mode_t[r], pol_t[r]});
      wt(6);
      `CHK("inh_idle", 1'b1, amp_on);
      contact <= ~pol_t[r];
      wt(6);
      `CHK("inh_active", logic'(mode_t[r] == IGNORE_INHIBIT_MODE), amp_on);
      contact <= pol_t[r];
      wt(6);
      `CHK("inh_back", logic'(mode_t[r] != LATCHED_INHIBIT_MODE), amp_on);
      if (mode_t[r] == LATCHED_INHIBIT_MODE) begin
        `CHK("inh_latch", 1'b1, prot_latched);
        ahb(1, ADDR_CLR, 32'h1);
        wt(3);
        `CHK("inh_clear", 1'b0, prot_latched);
        `CHK("inh_restore", 1'b1, amp_on);
      end
    end
    ahb(1, ADDR_INH, 32'h0);
    contact <= 1'b0;
    ahb(1, ADDR_OUT, 32'h0);
    wt(RAMP + 4);
  endtask : t_inhibit
  task automatic t_dfi();
    logic [3:0] oh;
    for (int s = 0; s < 5; s++) begin
      for (int k = 0; k < 4; k++) begin
        oh = (s == 0) ? 4'h0 : 4'h1 << (s - 1);
        summary <= oifc_sum_s'(k[1] ? ~oh : oh);
        ahb(1, ADDR_DFI, {28'h0, 3'(s), k[0]});
        wt(3);
        `CHK("dfi", logic'(k == 1 && s != 0), discrete_fault_indicator);
      end
    end
    summary <= '0;
    ahb(1, ADDR_DFI, 32'h0);
  endtask : t_dfi
  task automatic t_nv_init();
    contact <= 1'b1;
    sys_rst <= 1'b1;
    nv_inh_pol <= 1'b1;
    nv_inh_mode <= 2'h1;
    wt(12);
    sys_rst <= 1'b0;
    wt(4);
    `CHK("wait_aux", 1'b1, init_wait_aux);
    ahb(0, ADDR_INH, 0);
    `CHK("inh_restored", 32'h3, d);
    `CHK("pol_store", 1'b1, inh_pol_store);
    `CHK("mode_store", 2'h1, inh_mode_store);
    ahb(1, ADDR_INH, 32'h0);
    contact <= 1'b0;
    wt(6);
    `CHK("wait_done", 1'b0, init_wait_aux);
    `CHK("no_latch", 1'b0, prot_latched);
  endtask : t_nv_init
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    sink_option = 1'b0;
    regen_mode = 1'b0;
    summary = '0;
    nv_inh_pol = 1'b0;
    nv_inh_mode = 2'h0;
    // the inhibit contact stays open through power-up
    contact = 1'b0;
    fault_req = '0;
    wt(12);
    sys_rst <= 1'b0;
    wt(2);
    t_reset();
    t_enable();
    t_immediate();
    t_fault();
    t_inhibit();
    t_dfi();
    t_nv_init();
    conclude();
  end
endmodule : oifc_tb_top
`undef CHK
`default_nettype wire
